// ===== spb_pkg.sv
// Shared constants and types of the serial port with baud divider.
// Assumes one module clock; pin inputs arrive unsynchronised.
package spb_pkg;
    localparam int SPB_DATA_W = 8;
    localparam int SPB_SEL_W = 3;
    localparam int SPB_CNT_W = 11;
    // Pin vector positions
    localparam int SPB_PIN_SCK = 0;
    localparam int SPB_PIN_SS = 1;
    localparam int SPB_PIN_MOSI = 2;
    localparam int SPB_PIN_MISO = 3;
    // Reset values
    localparam logic [3:0] SPB_PIN_RST = 4'h2;
    localparam logic [7:0] SPB_DATA_RST = 8'h00;
    // Timing counts
    localparam logic [4:0] SPB_EDGE_LAST = 5'h0f;
    localparam logic [2:0] SPB_BIT_LAST = 3'h7;
    typedef enum logic [1:0] {SPB_IDLE, SPB_SHIFT, SPB_TAIL} spb_state_e;
endpackage : spb_pkg

// ===== spb_div_if.sv
// Link between the core and its baud divider.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface spb_div_if;
    import spb_pkg::*;
    logic run;
    logic [SPB_SEL_W-1:0] presel;
    logic [SPB_SEL_W-1:0] sel;
    logic tick;
    modport core (output run, output presel, output sel, input tick);
    modport div (input run, input presel, input sel, output tick);
endinterface : spb_div_if

// ===== spb_baud_div.sv
// Baud divider: one tick per half serial clock period.
// Assumes run is only raised for a master transfer.
`timescale 1ns/1ps
module spb_baud_div (
    input wire logic clock,
    input wire logic srst,
    input wire logic clk_en,
    spb_div_if.div dv
);
    import spb_pkg::*;

    typedef struct packed {
        logic [SPB_CNT_W-1:0] cnt;
    } spb_div_s;

    spb_div_s r_reg;
    spb_div_s r_next;
    logic [SPB_CNT_W-1:0] half;

    // Half period is (pre+1) * 2^sel, full period twice that
    always_comb
    begin
        half = SPB_CNT_W'({1'b0, dv.presel} + 4'h1) << dv.sel; // RULE_01 RULE_02 RULE_03
        r_next = r_reg;
        if (!dv.run)
            r_next.cnt = '0; // RULE_04
        else if (r_reg.cnt >= half - 1'b1) // Live rate change cannot overrun
            r_next.cnt = '0;
        else
            r_next.cnt = r_reg.cnt + 1'b1;
    end

    assign dv.tick = dv.run && clk_en && (r_reg.cnt >= half - 1'b1);

    // Counter register
    always_ff @(posedge clock)
    begin
        if (srst)
            r_reg <= '0;
        else if (clk_en)
            r_reg <= r_next;
    end

    a_tick_gated: assert property ( // RULE_04
        @(posedge clock) disable iff (srst)
        !dv.run && clk_en |=> r_reg.cnt == '0)
        else $error("divider runs while idle");
    a_div_base: assert property ( // RULE_01
        @(posedge clock) disable iff (srst)
        dv.run && clk_en && dv.presel == 3'h0 && dv.sel == 3'h0
        |-> dv.tick)
        else $error("base divisor is not two");
    a_div_three: assert property ( // RULE_02
        @(posedge clock) disable iff (srst)
        dv.tick && dv.presel == 3'h2 && dv.sel == 3'h0
        && $stable(dv.presel) ##1 dv.run && clk_en ##1 dv.run && clk_en
        |-> !dv.tick && !$past(dv.tick))
        else $error("preselect spacing wrong");
endmodule : spb_baud_div

// ===== spb_core.sv
// Serial port core: master/slave shifter, fault, low power.
// Assumes mode 0 format, MSB first, 8-bit frames; pins sync here.
// What this block does
// [RULE_01] Zero fields divide module clock by two
// [RULE_02] Preselect plus one multiplies select divisor
// [RULE_03] Divisor is (pre+1) times 2^(sel+1)
// [RULE_04] Divider runs only for master transfers
// [RULE_05] Auto select low during transfer, else high
// [RULE_06] Auto select needs master, both enables
// [RULE_07] Single wire uses one data pin
// [RULE_08] Single wire leaves other data pin free
// [RULE_09] Shared pin enable sets direction
// [RULE_10] Clock out as master, select in slave
// [RULE_11] Master select low sets mode fault if select output off
// [RULE_12] No fault when detect off or slave
// [RULE_13] Fault forces slave, outputs off, idle
// [RULE_14] Fault clears shared pin enable in single wire mode
// [RULE_15] Status read then control write clears fault
// [RULE_16] Fault discards pending received byte
// [RULE_17] Disabled core frozen, registers still writable
// [RULE_18] Halt in wait stops clock generation
// [RULE_19] Master transfer resumes after wait
// [RULE_20] Slave keeps shifting its chosen source
// [RULE_21] Slave completion deferred to wait exit
// [RULE_22] Clock stop freezes and resumes transfer
// [RULE_23] Data register reads zero after reset
`timescale 1ns/1ps
module spb_core (
    input wire logic clock,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic system_enable,
    input wire logic halt_in_wait,
    input wire logic cpu_wait,
    input wire logic ctrl1_write,
    input wire logic master_select,
    input wire logic select_output_enable,
    input wire logic fault_detect_enable,
    input wire logic ctrl2_write,
    input wire logic single_wire_select,
    input wire logic shared_pin_output_enable,
    input wire logic [spb_pkg::SPB_SEL_W-1:0] baud_preselect,
    input wire logic [spb_pkg::SPB_SEL_W-1:0] baud_select,
    input wire logic status_read,
    input wire logic data_write,
    input wire logic data_read,
    input wire logic [spb_pkg::SPB_DATA_W-1:0] data_in,
    output logic [spb_pkg::SPB_DATA_W-1:0] serial_data_register,
    output logic transfer_done_flag,
    output logic mode_fault_flag,
    output logic master_active,
    output logic shared_pin_oe_state,
    output logic busy,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic ss_n_in,
    output logic ss_n_out,
    output logic ss_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe
);
    import spb_pkg::*;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] pin;
        logic master;
        logic bidir_oe;
        logic fault;
        logic fault_armed;
        logic done;
        logic done_armed;
        logic [SPB_DATA_W-1:0] data;
        logic [SPB_DATA_W-1:0] tx;
        logic tx_full;
        logic [SPB_DATA_W-1:0] shreg;
        logic [SPB_DATA_W-1:0] hold;
        logic in_bit;
        spb_state_e st;
        logic [4:0] ecnt;
        logic sck;
        logic [2:0] bits;
        logic defer;
        logic wait_q;
        logic keep_dr;
    } spb_core_s;

    spb_core_s r_reg;
    spb_core_s r_next;
    logic halted;
    logic din;
    logic fault_now;
    logic rise;
    logic fall;
    logic auto_ss;

    spb_div_if dv ();

    spb_baud_div u_div (
        .clock(clock),
        .srst(srst),
        .clk_en(clk_en),
        .dv(dv)
    );

    // Divider gating and configuration
    assign halted = cpu_wait && halt_in_wait; // RULE_18
    assign dv.run = system_enable && r_reg.master && !halted
        && r_reg.st != SPB_IDLE; // RULE_04 RULE_19
    assign dv.presel = baud_preselect;
    assign dv.sel = baud_select;

    // Data pin choice by role and wire count
    always_comb
    begin
        if (r_reg.master)
            din = single_wire_select ? r_reg.pin[SPB_PIN_MOSI]
                : r_reg.pin[SPB_PIN_MISO]; // RULE_07 RULE_09
        else
            din = single_wire_select ? r_reg.pin[SPB_PIN_MISO]
                : r_reg.pin[SPB_PIN_MOSI]; // RULE_07 RULE_09
    end

    assign rise = r_reg.pin[SPB_PIN_SCK] && !r_reg.sck;
    assign fall = !r_reg.pin[SPB_PIN_SCK] && r_reg.sck;
    assign auto_ss = r_reg.master && select_output_enable
        && fault_detect_enable; // RULE_06
    assign fault_now = system_enable && r_reg.master && fault_detect_enable
        && !select_output_enable && !r_reg.pin[SPB_PIN_SS]; // RULE_11 RULE_12

    // Next state: sync, registers, shifter, fault, wait
    always_comb
    begin
        r_next = r_reg;
        r_next.s1 = {miso_in, mosi_in, ss_n_in, sck_in};
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        for (int i = 0; i < 4; i++)
        begin
            if (r_reg.s2[i] == r_reg.s3[i])
                r_next.pin[i] = r_reg.s3[i];
        end
        // Software side, live even while disabled
        if (ctrl2_write)
            r_next.bidir_oe = shared_pin_output_enable;
        // A pending fault keeps the role slave until it is cleared
        if (ctrl1_write && (!r_reg.fault || r_reg.fault_armed))
            r_next.master = master_select; // RULE_13 RULE_15
        if (data_write)
        begin
            r_next.tx = data_in;
            r_next.tx_full = 1'b1;
        end
        if (status_read)
        begin
            r_next.fault_armed = r_reg.fault;
            r_next.done_armed = r_reg.done;
        end
        if (data_read && r_reg.done_armed)
        begin
            r_next.done = 1'b0;
            r_next.done_armed = 1'b0;
        end
        if (ctrl1_write && r_reg.fault_armed)
        begin
            r_next.fault = 1'b0; // RULE_15
            r_next.fault_armed = 1'b0;
        end
        if (system_enable) // RULE_17
        begin
            // Wait entry drops a deferred byte, exit posts it
            r_next.wait_q = halted;
            if (halted && !r_reg.wait_q)
            begin
                r_next.defer = 1'b0; // RULE_21
                r_next.keep_dr = r_reg.pin[SPB_PIN_SS]; // RULE_20
            end
            if (!halted && r_reg.wait_q && r_reg.defer)
            begin
                r_next.defer = 1'b0;
                r_next.data = r_reg.hold; // RULE_21
                r_next.done = 1'b1;
            end
            if (r_reg.master)
            begin
                case (r_reg.st)
                    SPB_IDLE:
                    begin
                        if (r_reg.tx_full && !halted)
                        begin
                            r_next.shreg = r_reg.tx;
                            r_next.tx_full = 1'b0;
                            r_next.st = SPB_SHIFT;
                            r_next.ecnt = '0;
                        end
                    end
                    SPB_SHIFT:
                    begin
                        if (dv.tick) // RULE_19 RULE_22
                        begin
                            r_next.ecnt = r_reg.ecnt + 1'b1;
                            if (!r_reg.ecnt[0])
                            begin
                                r_next.sck = 1'b1;
                                r_next.in_bit = din;
                            end
                            else
                            begin
                                r_next.sck = 1'b0;
                                r_next.shreg = {r_reg.shreg[6:0], r_reg.in_bit};
                            end
                            if (r_reg.ecnt == SPB_EDGE_LAST)
                                r_next.st = SPB_TAIL;
                        end
                    end
                    SPB_TAIL:
                    begin
                        if (dv.tick)
                        begin
                            r_next.data = r_reg.shreg;
                            r_next.done = 1'b1;
                            r_next.st = SPB_IDLE;
                        end
                    end
                    default:
                        r_next.st = SPB_IDLE;
                endcase
                // Fault aborts and discards the frame
                if (fault_now)
                begin
                    r_next.fault = 1'b1; // RULE_11
                    r_next.master = 1'b0; // RULE_13
                    r_next.st = SPB_IDLE;
                    r_next.sck = 1'b0;
                    r_next.ecnt = '0;
                    r_next.data = r_reg.data; // RULE_16
                    r_next.done = r_reg.done;
                    if (single_wire_select)
                        r_next.bidir_oe = 1'b0; // RULE_14
                end
            end
            else
            begin
                // Slave follows the external clock
                r_next.sck = r_reg.pin[SPB_PIN_SCK]; // RULE_10
                r_next.st = SPB_IDLE;
                if (r_reg.pin[SPB_PIN_SS])
                begin
                    r_next.bits = '0;
                    if (!halted || r_reg.keep_dr)
                        r_next.shreg = r_reg.tx;
                end
                else
                begin
                    if (rise)
                        r_next.in_bit = din;
                    if (fall)
                    begin
                        r_next.shreg = {r_reg.shreg[6:0], r_reg.in_bit};
                        r_next.bits = r_reg.bits + 1'b1;
                        if (r_reg.bits == SPB_BIT_LAST)
                        begin
                            if (halted)
                            begin
                                r_next.defer = 1'b1; // RULE_21
                                r_next.hold = {r_reg.shreg[6:0], r_reg.in_bit};
                                if (r_reg.keep_dr)
                                    r_next.shreg = r_reg.tx; // RULE_20
                            end
                            else
                            begin
                                r_next.data = {r_reg.shreg[6:0], r_reg.in_bit};
                                r_next.done = 1'b1;
                            end
                        end
                    end
                end
            end
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            r_reg <= '0;
            r_reg.s2 <= SPB_PIN_RST;
            r_reg.s3 <= SPB_PIN_RST;
            r_reg.pin <= SPB_PIN_RST;
            r_reg.data <= SPB_DATA_RST; // RULE_23
        end
        else if (clk_en) // RULE_22
            r_reg <= r_next;
    end

    // Status outputs
    assign serial_data_register = r_reg.data;
    assign transfer_done_flag = r_reg.done;
    assign mode_fault_flag = r_reg.fault;
    assign master_active = r_reg.master;
    assign shared_pin_oe_state = r_reg.bidir_oe;
    assign busy = r_reg.st != SPB_IDLE;

    // Pin drivers by role and wire count
    assign sck_out = r_reg.sck;
    assign sck_oe = system_enable && r_reg.master; // RULE_10 RULE_13
    assign ss_n_out = r_reg.st == SPB_IDLE; // RULE_05
    assign ss_oe = system_enable && auto_ss; // RULE_06 RULE_10
    assign mosi_out = r_reg.shreg[7];
    assign mosi_oe = system_enable && r_reg.master
        && (!single_wire_select || r_reg.bidir_oe); // RULE_08 RULE_09
    assign miso_out = r_reg.shreg[7];
    assign miso_oe = system_enable && !r_reg.master && !r_reg.fault
        && !r_reg.pin[SPB_PIN_SS]
        && (!single_wire_select || r_reg.bidir_oe); // RULE_08 RULE_13

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    sequence s_clear_req;
        r_reg.fault_armed && ctrl1_write && clk_en;
    endsequence
    sequence s_last_half;
        r_reg.st == SPB_TAIL && dv.tick && !fault_now;
    endsequence

    a_fault_clear: assert property ( // RULE_15
        s_clear_req |=> !mode_fault_flag)
        else $error("mode fault not cleared");
    a_fault_cause: assert property ($rose(mode_fault_flag) // RULE_12
        |-> $past(fault_detect_enable) && $past(r_reg.master)
        && !$past(select_output_enable))
        else $error("fault raised without cause");
    a_fault_demote: assert property ($rose(mode_fault_flag) // RULE_13
        |-> !master_active && !busy && !sck_oe)
        else $error("fault left master active");
    a_fault_quiet: assert property (mode_fault_flag // RULE_13
        |-> !mosi_oe && !miso_oe && !sck_oe)
        else $error("outputs driven during fault");
    a_byte_done: assert property (s_last_half // RULE_01
        |=> transfer_done_flag && serial_data_register == $past(r_reg.shreg))
        else $error("master byte not posted");
    a_auto_select: assert property (ss_oe && busy |-> !ss_n_out) // RULE_05
        else $error("select high during transfer");
    a_wait_freeze: assert property (r_reg.master && halted // RULE_19
        && r_reg.wait_q && system_enable ##1 halted |-> $stable(r_reg.ecnt))
        else $error("master shifted in wait");
    a_off_quiet: assert property (!system_enable // RULE_17
        |-> !sck_oe && !ss_oe && !mosi_oe && !miso_oe)
        else $error("pins driven while disabled");
    a_single_free: assert property ( // RULE_08
        single_wire_select && master_active |-> !miso_oe)
        else $error("unused pin driven");
endmodule : spb_core

// ===== spb_slave_model.sv
// Partner model: external serial slave, clock idle low, MSB first.
// Assumes the bench clock runs it and it sees the resolved wires.
`timescale 1ns/1ps
module spb_slave_model (
    input wire logic clock,
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte
);
    logic [7:0] sh_reg = 8'h00;
    logic [7:0] rx_reg = 8'h00;
    logic smp_reg = 1'b0;
    logic sck_reg = 1'b0;
    logic junk_reg = 1'b0;
    // Reload while deselected, sample on rise, shift on fall
    always @(posedge clock)
    begin
        sck_reg <= sck;
        junk_reg <= ~junk_reg;
        if (ss_n)
            sh_reg <= tx_byte;
        else if (sck && !sck_reg)
            smp_reg <= mosi;
        else if (!sck && sck_reg)
        begin
            sh_reg <= {sh_reg[6:0], smp_reg};
            rx_reg <= {sh_reg[6:0], smp_reg};
        end
    end
    // A released line carries a pattern that keeps changing
    assign miso = ss_n ? junk_reg : sh_reg[7];
    assign rx_byte = rx_reg;
endmodule : spb_slave_model

// ===== spb_core_tb.sv
// Testbench of the serial core: divider, auto select, fault, low power.
// Assumes spb_slave_model on the four wires; master side only.
`timescale 1ns/1ps
module spb_core_tb;
    import spb_pkg::*;
    typedef struct {
        logic [7:0] rx_d;
        logic [7:0] tx_d;
        bit chk_rx;
    } spb_note_s;
    logic clock = 1'b0, srst = 1'b1, clk_en = 1'b1, system_enable = 1'b1;
    logic halt_in_wait = 1'b0, cpu_wait = 1'b0, ctrl1_write = 1'b0;
    logic master_select = 1'b1, select_output_enable = 1'b1;
    logic fault_detect_enable = 1'b1, ctrl2_write = 1'b0;
    logic single_wire_select = 1'b0, shared_pin_output_enable = 1'b0;
    logic [2:0] baud_preselect = 3'h0, baud_select = 3'h0;
    logic status_read = 1'b0, data_write = 1'b0, data_read = 1'b0;
    logic [7:0] data_in = 8'h00, s_tx = 8'h5a, s_rx, last_rx;
    logic [7:0] serial_data_register;
    logic transfer_done_flag, mode_fault_flag, master_active, busy;
    logic shared_pin_oe_state, sck_in, sck_out, sck_oe, ss_n_in, ss_n_out;
    logic ss_oe, mosi_in, mosi_out, mosi_oe, miso_in, miso_out, miso_oe;
    logic bench_ss_n = 1'b1, flip = 1'b0, s_miso, done_q = 1'b0;
    bit loose = 1'b0;
    int n_mismatch = 0, n_checks = 0;
    spb_note_s note_q[$];
    spb_note_s nt_m;
    logic [2:0] pre_t[6] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h1};
    logic [2:0] sel_t[6] = '{3'h0, 3'h1, 3'h2, 3'h0, 3'h0, 3'h2};

    spb_core i_dut (.clock, .srst, .clk_en, .system_enable, .halt_in_wait,
        .cpu_wait, .ctrl1_write, .master_select, .select_output_enable,
        .fault_detect_enable, .ctrl2_write, .single_wire_select,
        .shared_pin_output_enable, .baud_preselect, .baud_select,
        .status_read, .data_write, .data_read, .data_in,
        .serial_data_register, .transfer_done_flag, .mode_fault_flag,
        .master_active, .shared_pin_oe_state, .busy, .sck_in, .sck_out,
        .sck_oe, .ss_n_in, .ss_n_out, .ss_oe, .mosi_in, .mosi_out,
        .mosi_oe, .miso_in, .miso_out, .miso_oe);
    spb_slave_model i_slave (.clock, .sck(sck_in), .ss_n(ss_n_in),
        .mosi(mosi_in), .tx_byte(s_tx), .miso(s_miso), .rx_byte(s_rx));

    // Wire levels from every driver; undriven data lines keep changing
    assign sck_in = sck_oe ? sck_out : 1'b0;
    assign ss_n_in = ss_oe ? ss_n_out : bench_ss_n;
    assign mosi_in = mosi_oe ? mosi_out : flip;
    assign miso_in = miso_oe ? miso_out : s_miso;

    // Clock and filler pattern
    always #25 clock = ~clock;
    always @(posedge clock) flip <= ~flip;

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse
    task automatic bad(input logic [31:0] g, input logic [31:0] e);
        n_mismatch++;
        $display("unexpected at %0t: got %h expected %h", $time, g, e);
    endtask : bad
    task automatic chk1(input logic g, input logic e);
        n_checks++;
        if (g !== e) bad(32'(g), 32'(e));
    endtask : chk1
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) bad(32'(g), 32'(e));
    endtask : chk8
    task automatic chk_n(input int g, input int e);
        n_checks++;
        if (g != e) bad(g, e);
    endtask : chk_n

    // One master byte: note expectations, time each clock edge after the first
    task automatic xfer(input logic [2:0] pre, input logic [2:0] sel,
        input logic [7:0] d, input logic [7:0] rx);
        spb_note_s nt;
        int h;
        int gap;
        int edges;
        logic last;
        h = (int'(pre) + 1) << sel;
        nt.rx_d = rx;
        nt.tx_d = d;
        nt.chk_rx = h >= 6;
        if (h >= 6) last_rx = rx;
        note_q.push_back(nt);
        baud_preselect = pre;
        baud_select = sel;
        data_in = d;
        pulse(data_write);
        edges = 0;
        gap = 0;
        last = sck_out;
        while (transfer_done_flag !== 1'b1 && gap < 2000)
        begin
            tick(1);
            gap++;
            if (sck_out !== last)
            begin
                if (edges > 0 && !loose) chk_n(gap, h);
                chk1(ss_n_out, 1'b0);
                edges++;
                gap = 0;
                last = sck_out;
            end
        end
        chk_n(edges, 16);
        if (!loose) chk_n(gap, h);
        chk1(mode_fault_flag, 1'b0);
        pulse(status_read);
        pulse(data_read);
        chk1(ss_n_out, 1'b1);
        chk1(transfer_done_flag, 1'b0);
    endtask : xfer

    // Freeze by disable, halted wait or stopped clock; clock must hold
    task automatic stall(input int kind, input int d);
        int n;
        logic s;
        tick(d);
        n = 0;
        s = sck_out;
        if (kind == 0) system_enable = 1'b0;
        else if (kind == 1) cpu_wait = 1'b1;
        else clk_en = 1'b0;
        repeat (30)
        begin
            tick(1);
            n += int'(sck_out !== s);
            s = sck_out;
        end
        chk_n(n, 0);
        system_enable = 1'b1;
        cpu_wait = 1'b0;
        clk_en = 1'b1;
    endtask : stall

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    // Each finished transfer is compared with the oldest note
    always @(negedge clock)
    begin
        if (transfer_done_flag === 1'b1 && !done_q)
        begin
            if (note_q.size() == 0)
                chk_n(note_q.size(), 1);
            else
            begin
                nt_m = note_q.pop_front();
                chk8(s_rx, nt_m.tx_d);
                if (nt_m.chk_rx) chk8(serial_data_register, nt_m.rx_d);
            end
        end
        done_q <= (transfer_done_flag === 1'b1);
    end

    // Watchdog well beyond the longest run
    initial
    begin
        #4_000_000;
        n_mismatch++;
        results();
    end

    // Main sequence
    initial
    begin
        void'($urandom(32'hab63a646));
        tick(4);
        srst = 1'b0;
        tick(1);
        chk8(serial_data_register, SPB_DATA_RST);
        chk1(ss_n_out, 1'b1);
        pulse(ctrl1_write);
        tick(1);
        chk1(sck_oe, 1'b1);
        $display("test reset done");
        for (int i = 0; i < 6; i++)
            xfer(pre_t[i], sel_t[i], 8'ha5 ^ 8'(i), s_tx);
        for (int i = 0; i < 4; i++)
        begin
            s_tx = 8'($urandom);
            xfer(3'($urandom_range(7)), 3'($urandom_range(3)),
                8'($urandom), s_tx);
        end
        $display("test divider done");
        cpu_wait = 1'b1;
        xfer(3'h0, 3'h1, 8'h3c, s_tx);
        cpu_wait = 1'b0;
        halt_in_wait = 1'b1;
        loose = 1'b1;
        fork
            xfer(3'h0, 3'h1, 8'h96, s_tx);
            stall(1, 12);
        join
        fork
            xfer(3'h0, 3'h1, 8'h69, s_tx);
            stall(2, 12);
        join
        fork
            xfer(3'h0, 3'h1, 8'he1, s_tx);
            stall(0, 0);
        join
        loose = 1'b0;
        halt_in_wait = 1'b0;
        $display("test low power done");
        xfer(3'h1, 3'h2, 8'h0f, s_tx);
        select_output_enable = 1'b0;
        baud_select = 3'h3;
        data_in = 8'hc3;
        pulse(data_write);
        tick(40);
        bench_ss_n = 1'b0;
        tick(6);
        chk1(mode_fault_flag, 1'b1);
        chk1(master_active, 1'b0);
        chk1(busy, 1'b0);
        chk1(sck_oe | mosi_oe | miso_oe, 1'b0);
        chk8(serial_data_register, last_rx);
        bench_ss_n = 1'b1;
        tick(4);
        pulse(ctrl1_write);
        chk1(mode_fault_flag, 1'b1);
        chk1(master_active, 1'b0);
        pulse(status_read);
        pulse(ctrl1_write);
        tick(1);
        chk1(mode_fault_flag, 1'b0);
        chk1(master_active, 1'b1);
        fault_detect_enable = 1'b0;
        bench_ss_n = 1'b0;
        tick(8);
        chk1(mode_fault_flag, 1'b0);
        master_select = 1'b0;
        pulse(ctrl1_write);
        fault_detect_enable = 1'b1;
        tick(8);
        chk1(mode_fault_flag, 1'b0);
        chk1(sck_oe | ss_oe, 1'b0);
        bench_ss_n = 1'b1;
        master_select = 1'b1;
        tick(5);
        pulse(ctrl1_write);
        $display("test fault done");
        select_output_enable = 1'b1;
        single_wire_select = 1'b1;
        shared_pin_output_enable = 1'b1;
        pulse(ctrl2_write);
        tick(1);
        chk1(shared_pin_oe_state, 1'b1);
        chk1(mosi_oe, 1'b1);
        chk1(miso_oe, 1'b0);
        xfer(3'h0, 3'h3, 8'hb4, 8'hb4);
        select_output_enable = 1'b0;
        bench_ss_n = 1'b0;
        tick(6);
        chk1(shared_pin_oe_state, 1'b0);
        chk1(mosi_oe, 1'b0);
        $display("test single wire done");
        results();
    end
endmodule : spb_core_tb
